//--- hdl/hpdp_bank.sv
// Port-disable and power configuration bank with APB slave and port enable logic
`timescale 1ns/1ps
module hpdp_bank
    import hpdp_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [HPDP_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [1:0]             port_off_strap_pins,
    input  wire logic [3:0]             port_remap_map,
    output logic      [1:0]             port_enable,
    output logic      [1:0]             enabled_port_count,
    output logic      [1:0]             port1_number,
    output logic      [1:0]             port2_number,
    output logic      [7:0]             self_powered_power_value,
    output logic      [7:0]             bus_powered_power_value,
    output logic      [7:0]             controller_self_powered_current_value
);
    logic [7:0]  bus_powered_port_off_bits_ff;
    logic [7:0]  nxt_bus_powered_port_off_bits;
    logic [7:0]  max_sp_ff;
    logic [7:0]  nxt_max_sp;
    logic [7:0]  max_bp_ff;
    logic [7:0]  nxt_max_bp;
    logic [7:0]  ctrl_cur_ff;
    logic [7:0]  nxt_ctrl_cur;
    logic [2:0]  mode_ff;
    logic [2:0]  nxt_mode;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        pready_ff;
    logic        nxt_pready;
    logic        pslverr_ff;
    logic        nxt_pslverr;
    logic [1:0]  port_enable_ff;
    logic [1:0]  nxt_port_enable;
    logic [1:0]  count_ff;
    logic [1:0]  nxt_count;
    logic [1:0]  num1_ff;
    logic [1:0]  nxt_num1;
    logic [1:0]  num2_ff;
    logic [1:0]  nxt_num2;
    logic [1:0]  off_sel;
    logic [1:0]  slot_en;
    logic [1:0]  slot_num1;
    logic [1:0]  slot_num2;
    logic        access;
    logic        commit;
    logic        hit;
    logic [7:0]  wbyte;

    // Access marks the first access-phase cycle; the transfer completes one cycle later
    assign access = psel & penable & ~pready_ff;
    // Write lands on the edge where the master sees pready high
    assign commit = psel & penable & pready_ff & pwrite & pstrb[0];
    assign wbyte  = pstrb[0] ? pwdata[7:0] : 8'h00;

    always_comb begin
        off_sel = {bus_powered_port_off_bits_ff[BIT_PORT2],
                   bus_powered_port_off_bits_ff[BIT_PORT1]};
        if (mode_ff[BIT_DEFAULT_CFG]) begin
            off_sel = port_off_strap_pins;
        end
        // Self-powered mask not in this bank, so only bus-powered mode or the default-config straps mask
        if (!mode_ff[BIT_BUS_POWERED] && !mode_ff[BIT_DEFAULT_CFG]) begin
            off_sel = 2'h0;
        end
    end

    hpdp_port_slot u_slot1 (
        .disabled    (off_sel[0]),
        .lower_count (2'h0),
        .enabled     (slot_en[0]),
        .logical_num (slot_num1)
    );

    hpdp_port_slot u_slot2 (
        .disabled    (off_sel[1]),
        .lower_count ({1'b0, slot_en[0]}),
        .enabled     (slot_en[1]),
        .logical_num (slot_num2)
    );

    always_comb begin
        nxt_port_enable = slot_en;
        nxt_count       = 2'({1'b0, slot_en[0]} + {1'b0, slot_en[1]});
        nxt_num1        = slot_num1;
        nxt_num2        = slot_num2;
        if (mode_ff[BIT_REMAP_EN]) begin
            // Remap register owns numbering; zero number means port off
            nxt_num1        = port_remap_map[1:0];
            nxt_num2        = port_remap_map[3:2];
            nxt_port_enable = {|port_remap_map[3:2], |port_remap_map[1:0]};
            nxt_count       = 2'({1'b0, nxt_port_enable[0]} + {1'b0, nxt_port_enable[1]});
        end
    end

    // Read data and error are prepared in the first access cycle
    always_comb begin
        nxt_prdata   = prdata_ff;
        nxt_pready   = 1'b0;
        nxt_pslverr  = 1'b0;
        hit          = 1'b1;
        if (access) begin
            nxt_pready = 1'b1;
            nxt_prdata = 32'h0;
            unique case (paddr)
                ADDR_PORT_OFF_BP: begin
                    nxt_prdata[7:0] = bus_powered_port_off_bits_ff;
                end
                ADDR_SELF_POWERED_POWER_VALUE: begin
                    nxt_prdata[7:0] = max_sp_ff;
                end
                ADDR_BUS_POWERED_POWER_VALUE: begin
                    nxt_prdata[7:0] = max_bp_ff;
                end
                ADDR_CTRL_CUR_SP: begin
                    nxt_prdata[7:0] = ctrl_cur_ff;
                end
                ADDR_MODE_CTRL: begin
                    nxt_prdata[2:0] = mode_ff;
                end
                ADDR_PORT_STATUS: begin
                    nxt_prdata[LSB_STAT_EN+:2]    = port_enable_ff;
                    nxt_prdata[LSB_STAT_COUNT+:2] = count_ff;
                    nxt_prdata[LSB_STAT_LOG1+:2]  = num1_ff;
                    nxt_prdata[LSB_STAT_LOG2+:2]  = num2_ff;
                    if (pwrite) begin
                        nxt_pslverr = 1'b1;
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            if (!hit) begin
                nxt_pslverr = 1'b1;
            end
        end
    end

    // Register updates wait for the completing edge, so a held request writes once
    always_comb begin
        nxt_bus_powered_port_off_bits = bus_powered_port_off_bits_ff;
        nxt_max_sp   = max_sp_ff;
        nxt_max_bp   = max_bp_ff;
        nxt_ctrl_cur = ctrl_cur_ff;
        nxt_mode     = mode_ff;
        if (commit) begin
            unique case (paddr)
                ADDR_PORT_OFF_BP: begin
                    nxt_bus_powered_port_off_bits = wbyte;
                end
                ADDR_SELF_POWERED_POWER_VALUE: begin
                    nxt_max_sp = wbyte;
                end
                ADDR_BUS_POWERED_POWER_VALUE: begin
                    nxt_max_bp = wbyte;
                end
                ADDR_CTRL_CUR_SP: begin
                    nxt_ctrl_cur = wbyte;
                end
                ADDR_MODE_CTRL: begin
                    nxt_mode = wbyte[2:0];
                end
                default: begin
                    // Status and unmapped writes are refused with pslverr
                    nxt_mode = mode_ff;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_powered_port_off_bits_ff <= RST_BYTE;
            max_sp_ff      <= RST_BYTE;
            max_bp_ff      <= RST_BYTE;
            ctrl_cur_ff    <= RST_BYTE;
            mode_ff        <= RST_MODE;
            prdata_ff      <= 32'h0;
            pready_ff      <= 1'b0;
            pslverr_ff     <= 1'b0;
            port_enable_ff <= RST_PORT_EN;
            count_ff       <= RST_PORT_COUNT;
            num1_ff        <= RST_NUM_PORT1;
            num2_ff        <= RST_NUM_PORT2;
        end else begin
            bus_powered_port_off_bits_ff <= nxt_bus_powered_port_off_bits;
            max_sp_ff      <= nxt_max_sp;
            max_bp_ff      <= nxt_max_bp;
            ctrl_cur_ff    <= nxt_ctrl_cur;
            mode_ff        <= nxt_mode;
            prdata_ff      <= nxt_prdata;
            pready_ff      <= nxt_pready;
            pslverr_ff     <= nxt_pslverr;
            port_enable_ff <= nxt_port_enable;
            count_ff       <= nxt_count;
            num1_ff        <= nxt_num1;
            num2_ff        <= nxt_num2;
        end
    end

    // No clamp at the 100 mA code: software owns that limit
    assign prdata                                = prdata_ff;
    assign pready                                = pready_ff;
    assign pslverr                               = pslverr_ff;
    assign port_enable                           = port_enable_ff;
    assign enabled_port_count                    = count_ff;
    assign port1_number                          = num1_ff;
    assign port2_number                          = num2_ff;
    assign self_powered_power_value              = max_sp_ff;
    assign bus_powered_power_value               = max_bp_ff;
    assign controller_self_powered_current_value = ctrl_cur_ff;
endmodule

//--- hdl/hpdp_pkg.sv
// Package: register map, field positions and constants of the port-disable/power bank
package hpdp_pkg;
    localparam int unsigned    HPDP_ADDR_W       = 12;
    localparam int unsigned    HPDP_PORTS        = 2;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]     IDX_PORT_OFF_BP   = 8'h0B;
    localparam logic [7:0]     IDX_SELF_POWERED_POWER_VALUE    = 8'h0C;
    localparam logic [7:0]     IDX_BUS_POWERED_POWER_VALUE    = 8'h0D;
    localparam logic [7:0]     IDX_CTRL_CUR_SP   = 8'h0E;
    localparam logic [7:0]     IDX_MODE_CTRL     = 8'h20;
    localparam logic [7:0]     IDX_PORT_STATUS   = 8'h21;
    localparam logic [11:0]    ADDR_PORT_OFF_BP  = {2'h0, IDX_PORT_OFF_BP, 2'h0};
    localparam logic [11:0]    ADDR_SELF_POWERED_POWER_VALUE   = {2'h0, IDX_SELF_POWERED_POWER_VALUE, 2'h0};
    localparam logic [11:0]    ADDR_BUS_POWERED_POWER_VALUE   = {2'h0, IDX_BUS_POWERED_POWER_VALUE, 2'h0};
    localparam logic [11:0]    ADDR_CTRL_CUR_SP  = {2'h0, IDX_CTRL_CUR_SP, 2'h0};
    localparam logic [11:0]    ADDR_MODE_CTRL    = {2'h0, IDX_MODE_CTRL, 2'h0};
    localparam logic [11:0]    ADDR_PORT_STATUS  = {2'h0, IDX_PORT_STATUS, 2'h0};
    // Reset values
    localparam logic [7:0]     RST_BYTE          = 8'h00;
    localparam logic [2:0]     RST_MODE          = 3'h0;
    // All ports on and numbered in order until the bank is configured
    localparam logic [1:0]     RST_PORT_EN       = 2'h3;
    localparam logic [1:0]     RST_PORT_COUNT    = 2'h2;
    localparam logic [1:0]     RST_NUM_PORT1     = 2'h1;
    localparam logic [1:0]     RST_NUM_PORT2     = 2'h2;
    // Port-disable mask: bit 1 is port 1, bit 2 is port 2
    localparam int unsigned    BIT_PORT1         = 1;
    localparam int unsigned    BIT_PORT2         = 2;
    // Mode control fields
    localparam int unsigned    BIT_REMAP_EN      = 0;
    localparam int unsigned    BIT_DEFAULT_CFG   = 1;
    localparam int unsigned    BIT_BUS_POWERED   = 2;
    // Status fields
    localparam int unsigned    LSB_STAT_EN       = 0;
    localparam int unsigned    LSB_STAT_COUNT    = 2;
    localparam int unsigned    LSB_STAT_LOG1     = 4;
    localparam int unsigned    LSB_STAT_LOG2     = 6;
    // Units
    localparam int unsigned    POWER_UNIT_MA     = 2;
    localparam int unsigned    POWER_LIMIT_MA    = 100;
    localparam logic [7:0]     POWER_LIMIT_CODE  = 8'(POWER_LIMIT_MA / POWER_UNIT_MA);
endpackage

//--- hdl/hpdp_port_slot.sv
// One downstream port: enable and contiguous logical number
`timescale 1ns/1ps
module hpdp_port_slot
    import hpdp_pkg::*;
(
    input  wire logic       disabled,
    input  wire logic [1:0] lower_count,
    output logic            enabled,
    output logic [1:0]      logical_num
);
    always_comb begin
        enabled     = ~disabled;
        // Number follows the enabled ports below it, so numbering stays contiguous
        logical_num = enabled ? 2'(lower_count + 2'h1) : 2'h0;
    end
endmodule

//--- verification/hpdp_host_model.sv
// Partner model: upstream host turning reported power codes into milliamps
`timescale 1ns/1ps
module hpdp_host_model (
    input  wire logic [7:0] sp_code,
    input  wire logic [7:0] bp_code,
    input  wire logic [7:0] cur_code,
    output logic      [8:0] sp_ma,
    output logic      [8:0] bp_ma,
    output logic      [8:0] cur_ma
);
    // Codes are 2 mA steps; the embedded peripheral is taken to report zero
    assign sp_ma  = {sp_code, 1'b0};
    assign bp_ma  = {bp_code, 1'b0};
    assign cur_ma = {cur_code, 1'b0};
endmodule

//--- verification/hpdp_bank_chk.sv
// Checker: bus timing and register-to-output relations of the bank
`timescale 1ns/1ps
module hpdp_bank_chk
    import hpdp_pkg::*;
(
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [HPDP_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [1:0]             enabled_port_count,
    input wire logic [1:0]             port_enable,
    input wire logic [1:0]             port1_number,
    input wire logic [1:0]             port2_number,
    input wire logic [7:0]             self_powered_power_value,
    input wire logic [7:0]             bus_powered_power_value,
    input wire logic [7:0]             controller_self_powered_current_value
);
    logic wr_ok;
    assign wr_ok = pready && psel && penable && pwrite && pstrb[0] && !pslverr;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready && $past(psel && penable))
        else $error("pslverr without a transfer");
    a_unmapped_err: assert property (psel && penable && !pready && paddr == 12'hFFC
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_sp_follows: assert property (wr_ok && paddr == ADDR_SELF_POWERED_POWER_VALUE
        |=> self_powered_power_value == $past(pwdata[7:0]))
        else $error("self-powered value not updated");
    a_bp_follows: assert property (wr_ok && paddr == ADDR_BUS_POWERED_POWER_VALUE
        |=> bus_powered_power_value == $past(pwdata[7:0]))
        else $error("bus-powered value not updated");
    a_cur_follows: assert property (wr_ok && paddr == ADDR_CTRL_CUR_SP
        |=> controller_self_powered_current_value == $past(pwdata[7:0]))
        else $error("controller current not updated");
    a_count_sum: assert property (enabled_port_count == port_enable[0] + port_enable[1])
        else $error("port count differs from enables");
    a_num1_off_zero: assert property (!port_enable[0] |-> port1_number == 2'h0)
        else $error("disabled port 1 still numbered");
    a_num2_off_zero: assert property (!port_enable[1] |-> port2_number == 2'h0)
        else $error("disabled port 2 still numbered");
endmodule

//--- verification/test_hpdp_bank.sv
// Testbench: register access, port enable table and refusals of the bank
`timescale 1ns/1ps
module test_hpdp_bank;
    import hpdp_pkg::*;
    typedef struct packed {logic [7:0] mode; logic [7:0] mask; logic [1:0] strap;
        logic [3:0] map; logic [7:0] exp;} hpdp_row_t;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, port_remap_map;
    logic [1:0]  port_off_strap_pins, port_enable, enabled_port_count, port1_number, port2_number;
    logic [7:0]  self_powered_power_value, bus_powered_power_value;
    logic [7:0]  controller_self_powered_current_value;
    logic [8:0]  sp_ma, bp_ma, cur_ma;
    logic [11:0] regs [4] = '{ADDR_PORT_OFF_BP, ADDR_SELF_POWERED_POWER_VALUE, ADDR_BUS_POWERED_POWER_VALUE, ADDR_CTRL_CUR_SP};
    int          err_count, checks_done;
    // Mode, mask, straps, remap map, expected status
    hpdp_row_t   rows [9] = '{'{8'h04, 8'h00, 2'h0, 4'h0, 8'h9B}, '{8'h04, 8'h02, 2'h0, 4'h0, 8'h46},
        '{8'h04, 8'h04, 2'h0, 4'h0, 8'h15}, '{8'h04, 8'h06, 2'h0, 4'h0, 8'h00},
        '{8'h04, 8'hF9, 2'h0, 4'h0, 8'h9B}, '{8'h00, 8'h06, 2'h0, 4'h0, 8'h9B},
        '{8'h06, 8'h00, 2'h1, 4'h0, 8'h46}, '{8'h02, 8'h06, 2'h2, 4'h0, 8'h15},
        '{8'h05, 8'h06, 2'h0, 4'h6, 8'h6B}};
    hpdp_bank u_hpdp_bank (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .port_off_strap_pins, .port_remap_map, .port_enable,
        .enabled_port_count, .port1_number, .port2_number, .self_powered_power_value,
        .bus_powered_power_value, .controller_self_powered_current_value);
    hpdp_host_model u_hpdp_host_model (.sp_code(self_powered_power_value),
        .bp_code(bus_powered_power_value), .cur_code(controller_self_powered_current_value),
        .sp_ma(sp_ma), .bp_ma(bp_ma), .cur_ma(cur_ma));
    task automatic finish_test;
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next setup never reassigns psel in this step
        @(posedge ref_clk);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        finish_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        port_off_strap_pins = 2'h0;
        port_remap_map = 4'h0;
        rst_n = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            port_off_strap_pins <= rows[i].strap;
            port_remap_map <= rows[i].map;
            apb(1'b1, ADDR_MODE_CTRL, {24'h0, rows[i].mode}, 4'hF, rd, er);
            apb(1'b1, ADDR_PORT_OFF_BP, {24'h0, rows[i].mask}, 4'hF, rd, er);
            apb(1'b0, ADDR_PORT_STATUS, 32'h0, 4'hF, rd, er);
            chk("status", {24'h0, rows[i].exp}, rd);
            chk("enable", {30'h0, rows[i].exp[1:0]}, {30'h0, port_enable});
            chk("numbers", {28'h0, rows[i].exp[7:4]}, {28'h0, port2_number, port1_number});
            chk("count", {30'h0, rows[i].exp[3:2]}, {30'h0, enabled_port_count});
        end
        // Limit code keeps software within the 100 mA ceiling
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, regs[i], {24'hFFFFFF, POWER_LIMIT_CODE}, 4'h1, rd, er);
            apb(1'b0, regs[i], 32'h0, 4'hF, rd, er);
            chk("power reg", {24'h0, POWER_LIMIT_CODE}, rd);
        end
        chk("sp mA", POWER_LIMIT_MA, {23'h0, sp_ma});
        chk("bp mA", POWER_LIMIT_MA, {23'h0, bp_ma});
        chk("cur mA", POWER_LIMIT_MA, {23'h0, cur_ma});
        apb(1'b1, ADDR_SELF_POWERED_POWER_VALUE, 32'h11, 4'hE, rd, er);
        apb(1'b0, ADDR_SELF_POWERED_POWER_VALUE, 32'h0, 4'hF, rd, er);
        chk("strobe off", {24'h0, POWER_LIMIT_CODE}, rd);
        apb(1'b0, 12'hFFC, 32'h0, 4'hF, rd, er);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, ADDR_PORT_STATUS, 32'h0, 4'hF, rd, er);
        chk("status write", 32'h1, {31'h0, er});
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("reset enable", 32'h3, {30'h0, port_enable});
        chk("reset count", 32'h2, {30'h0, enabled_port_count});
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0, 4'hF, rd, er);
            chk("reset value", 32'h0, rd);
        end
        finish_test;
    end
endmodule
bind hpdp_bank hpdp_bank_chk u_hpdp_bank_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .enabled_port_count, .port_enable,
    .port1_number, .port2_number,
    .self_powered_power_value, .bus_powered_power_value, .controller_self_powered_current_value);
